// file: hdl/dcts_top.sv
// one dma channel: apb registers, transfer sequencing, address stepping
// assumes synchronous pins, a 16-bit memory bus and an external arbiter
`timescale 1ns/1ps
module dcts_top
    import dcts_pkg::*;
#(
    parameter int AW = 24,
    parameter int CW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic bus_request,
    input wire logic bus_grant,
    input wire logic req_n,
    output logic ack_n,
    input wire logic peripheral_control_line_n,
    output logic transfer_complete_strobe_n,
    output logic lower_byte_strobe_n,
    output logic upper_byte_strobe_n,
    output logic addr_strobe_n,
    output logic mem_read,
    output logic [AW-1:0] mem_addr,
    input wire logic memory_cycle_ack_n,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe
);
    typedef struct packed {
        logic [1:0] dtype;
        logic port;
        logic [1:0] size;
        logic [1:0] request_gen_sel;
        logic [1:0] mstep;
        logic [1:0] dstep;
        logic [AW-1:0] memory_address_reg;
        logic [AW-1:0] device_address_reg;
        logic [CW-1:0] mtc;
        logic dir;
        logic act;
        logic cfg_err;
        logic done;
        logic first;
        dcts_st_t st;
        logic [1:0] part;
        logic rd_phase;
        logic pack;
        logic dtk_seen;
        logic rdy_seen;
        logic [15:0] hold;
        logic ack_n;
        logic dtc_n;
        logic lds_n;
        logic uds_n;
        logic as_n;
        logic rw;
        logic [AW-1:0] addr;
        logic [15:0] dout;
        logic doe;
        logic breq;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } dcts_state_t;

    dcts_state_t s;
    dcts_state_t n;

    logic dual;
    logic [2:0] nparts;
    logic last_part;
    logic can_pack;
    logic want;
    logic cfg_bad;
    logic start_wr;
    logic op_end;
    logic wide_n;
    logic strb_n;
    logic [3:0] mamt;
    logic [3:0] damt;
    logic [CW-1:0] dec;

    // explicit addressing for types 00 and 01, implicit otherwise
    assign dual = ~s.dtype[1];
    // parts per operand: operand size over port size, at least one
    assign nparts = (s.port == PORT_16) ?
        ((s.size == SIZE_LONG) ? 3'h2 : 3'h1) : (3'h1 << s.size);
    assign last_part = (3'(s.part) == nparts - 3'h1);
    // packing only with auto requests and both addresses counting
    assign can_pack = dual && (s.port == PORT_16) &&
        (s.size == SIZE_BYTE) && !s.request_gen_sel[1] &&
        (s.mstep != STEP_NONE) && (s.dstep != STEP_NONE);
    // mixed mode auto-requests only the first operand
    assign want = !s.request_gen_sel[1] || !req_n ||
        (s.request_gen_sel == REQUEST_GEN_SEL_MIX && s.first);
    // per-operand steps
    assign mamt = s.pack ? 4'h2 : (4'h1 << s.size);
    assign damt = (s.port == PORT_16 && s.size == SIZE_BYTE) ?
        (s.pack ? 4'h2 : 4'h1) : {nparts, 1'b0};
    assign dec = s.pack ? CW'(2) : CW'(1);

    // refused combinations, checked when software starts the channel
    assign cfg_bad = (s.size == SIZE_RSVD) ||
        (s.mstep == STEP_RSVD) || (s.dstep == STEP_RSVD) ||
        (s.dtype == TYPE_ACK) || (s.mtc == '0) ||
        (!dual && (s.port == PORT_8) && (s.size != SIZE_BYTE)) ||
        (!dual && (s.port == PORT_16) && (s.size != SIZE_WORD)) ||
        (dual && (s.port == PORT_16) && (s.size == SIZE_BYTE) &&
         s.request_gen_sel[1]);

    function automatic logic [AW-1:0] step_addr(
        input logic [AW-1:0] a,
        input logic [1:0] sel,
        input logic [3:0] amt
    );
        logic [AW-1:0] r;
        r = a;
        if (sel == STEP_UP) begin
            r = a + AW'(amt);
        end else if (sel == STEP_DOWN) begin
            r = a - AW'(amt);
        end
        return r;
    endfunction

    // next state: bus slave, sequencer, then registered pin values
    always_comb begin
        n = s;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        start_wr = 1'b0;
        op_end = 1'b0;
        // one wait state so read data leaves a flop
        if (psel && penable && !s.pready) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            case (paddr)
                OFF_DCR: begin
                    n.prdata[DCR_TYPE_LSB +: 2] = s.dtype;
                    n.prdata[DCR_PORT_BIT] = s.port;
                end
                OFF_OCR: begin
                    n.prdata[OCR_SIZE_LSB +: 2] = s.size;
                    n.prdata[OCR_REQUEST_GEN_SEL_LSB +: 2] = s.request_gen_sel;
                end
                OFF_SCR: begin
                    n.prdata[SCR_MAC_LSB +: 2] = s.mstep;
                    n.prdata[SCR_DAC_LSB +: 2] = s.dstep;
                end
                OFF_MAR: n.prdata[AW-1:0] = s.memory_address_reg;
                OFF_DAR: n.prdata[AW-1:0] = s.device_address_reg;
                OFF_MTC: n.prdata[CW-1:0] = s.mtc;
                OFF_CTL: n.prdata[CTL_DIR_BIT] = s.dir;
                OFF_STAT: begin
                    n.prdata[STAT_ACT_BIT] = s.act;
                    n.prdata[STAT_CFG_BIT] = s.cfg_err;
                    n.prdata[STAT_DONE_BIT] = s.done;
                    n.prdata[STAT_PCL_BIT] = peripheral_control_line_n;
                end
                default: n.pslverr = 1'b1;
            endcase
        end
        // writes land on the completing edge; setup frozen while active
        if (psel && penable && s.pready && pwrite) begin
            case (paddr)
                OFF_DCR: if (!s.act) begin
                    n.dtype = pwdata[DCR_TYPE_LSB +: 2];
                    n.port = pwdata[DCR_PORT_BIT];
                end
                OFF_OCR: if (!s.act) begin
                    n.size = pwdata[OCR_SIZE_LSB +: 2];
                    n.request_gen_sel = pwdata[OCR_REQUEST_GEN_SEL_LSB +: 2];
                end
                OFF_SCR: if (!s.act) begin
                    n.mstep = pwdata[SCR_MAC_LSB +: 2];
                    n.dstep = pwdata[SCR_DAC_LSB +: 2];
                end
                OFF_MAR: if (!s.act) n.memory_address_reg = pwdata[AW-1:0];
                OFF_DAR: if (!s.act) n.device_address_reg = pwdata[AW-1:0];
                OFF_MTC: if (!s.act) n.mtc = pwdata[CW-1:0];
                OFF_CTL: if (!s.act) begin
                    n.dir = pwdata[CTL_DIR_BIT];
                    start_wr = pwdata[CTL_START_BIT];
                end
                OFF_STAT: begin
                    if (pwdata[STAT_CFG_BIT]) n.cfg_err = 1'b0;
                    if (pwdata[STAT_DONE_BIT]) n.done = 1'b0;
                end
                default: ;
            endcase
        end
        // start: flag a bad setup instead of running
        if (start_wr) begin
            if (cfg_bad) begin
                n.cfg_err = 1'b1;
            end else begin
                n.act = 1'b1;
                n.first = 1'b1;
            end
        end
        // sequencer
        unique case (s.st)
            ST_IDLE: begin
                if (s.act && want) n.st = ST_ARB;
            end
            ST_ARB: begin
                if (bus_grant) begin
                    n.dtk_seen = 1'b0;
                    n.rdy_seen = 1'b0;
                    n.part = 2'h0;
                    n.rd_phase = 1'b1;
                    // pack only when both sides are word aligned
                    n.pack = can_pack && !s.memory_address_reg[0] && !s.device_address_reg[0] &&
                        (s.mtc != CW'(1));
                    n.st = dual ? ST_DCYC : ST_SACK;
                end
            end
            ST_SACK: begin
                if (!peripheral_control_line_n) begin
                    n.rdy_seen = 1'b1;
                end
                // device to memory: ack counts only once strobes are out
                if (!memory_cycle_ack_n && (s.dir || s.rdy_seen)) begin
                    n.dtk_seen = 1'b1;
                end
                if (s.dtk_seen && s.rdy_seen) n.st = ST_SDTC;
            end
            ST_SDTC: n.st = ST_SEND;
            ST_SEND: op_end = 1'b1;
            ST_DCYC: begin
                if (!memory_cycle_ack_n) begin
                    if (s.rd_phase) begin
                        if (!s.uds_n && !s.lds_n) begin
                            n.hold = data_in;
                        end else begin
                            n.hold = {8'h00, s.addr[0] ?
                                data_in[7:0] : data_in[15:8]};
                        end
                    end
                    n.st = ST_DEND;
                end
            end
            ST_DEND: begin
                if (s.rd_phase) begin
                    n.rd_phase = 1'b0;
                    n.st = ST_DCYC;
                end else if (last_part) begin
                    op_end = 1'b1;
                end else begin
                    n.part = s.part + 2'h1;
                    n.rd_phase = 1'b1;
                    n.st = ST_DCYC;
                end
            end
        endcase
        // operand done: step addresses, count one operand per request, two when packed
        if (op_end) begin
            n.memory_address_reg = step_addr(s.memory_address_reg, s.mstep, mamt);
            if (dual) n.device_address_reg = step_addr(s.device_address_reg, s.dstep, damt);
            n.mtc = s.mtc - dec;
            n.first = 1'b0;
            n.st = ST_IDLE;
            if (s.mtc <= dec) begin
                n.act = 1'b0;
                n.done = 1'b1;
            end
        end
        // pin values follow the next state so every pin is a flop
        wide_n = (n.port == PORT_16) &&
            ((n.size != SIZE_BYTE) || n.pack);
        n.breq = (n.st != ST_IDLE);
        n.ack_n = !(n.st == ST_SACK || n.st == ST_SDTC);
        n.dtc_n = !(n.st == ST_SDTC);
        n.as_n = n.ack_n && (n.st != ST_DCYC);
        n.rw = dual ? n.rd_phase : n.dir;
        if (!dual) begin
            n.addr = n.memory_address_reg;
        end else if (n.rd_phase == n.dir) begin
            n.addr = n.memory_address_reg + (wide_n ? AW'({n.part, 1'b0}) : AW'(n.part));
        end else begin
            n.addr = n.device_address_reg + AW'({n.part, 1'b0});
        end
        // memory reads strobe at once, device reads wait for ready
        strb_n = !((!n.ack_n && (n.dir || n.rdy_seen)) ||
            n.st == ST_DCYC);
        n.uds_n = strb_n || (!wide_n && n.addr[0]);
        n.lds_n = strb_n || (!wide_n && !n.addr[0]);
        n.doe = (n.st == ST_DCYC) && !n.rd_phase;
        n.dout = wide_n ? n.hold : {n.hold[7:0], n.hold[7:0]};
    end

    // all state in one register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.ack_n <= 1'b1;
            s.dtc_n <= 1'b1;
            s.lds_n <= 1'b1;
            s.uds_n <= 1'b1;
            s.as_n <= 1'b1;
            s.rw <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign bus_request = s.breq;
    assign ack_n = s.ack_n;
    assign transfer_complete_strobe_n = s.dtc_n;
    assign lower_byte_strobe_n = s.lds_n;
    assign upper_byte_strobe_n = s.uds_n;
    assign addr_strobe_n = s.as_n;
    assign mem_read = s.rw;
    assign mem_addr = s.addr;
    assign data_out = s.dout;
    assign data_oe = s.doe;

    // checks on the sequencer
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_dtc_fall;
        $fell(transfer_complete_strobe_n) ##0
            (!lower_byte_strobe_n || !upper_byte_strobe_n);
    endsequence

    sequence s_strobes_off;
        lower_byte_strobe_n && upper_byte_strobe_n &&
            transfer_complete_strobe_n;
    endsequence

    a_ready_low_seen: assert property (
        s.st == ST_SACK && !peripheral_control_line_n |=> s.rdy_seen)
        else $error("ready low not recorded");

    a_end_needs_both: assert property (
        $fell(transfer_complete_strobe_n) |->
            $past(s.dtk_seen) && $past(s.rdy_seen))
        else $error("cycle ended without both answers");

    a_dtc_then_negate: assert property (
        s_dtc_fall |=> s_strobes_off)
        else $error("strobes not negated after complete strobe");

    a_strobe_after_rdy: assert property (
        !ack_n && !mem_read &&
            !(lower_byte_strobe_n && upper_byte_strobe_n) |->
            s.rdy_seen)
        else $error("device strobes before ready");

    a_byte_port_lane: assert property (
        s.st == ST_SACK && s.port == PORT_8 |->
            lower_byte_strobe_n || upper_byte_strobe_n)
        else $error("8-bit port drove both lanes");

    a_count_per_op: assert property (
        s.st == ST_DEND && !s.rd_phase && !last_part |=>
            s.mtc == $past(s.mtc))
        else $error("counter moved on a part cycle");

    a_single_step: assert property (
        s.st == ST_SEND && s.mstep == STEP_UP && s.size == SIZE_BYTE |=>
            s.memory_address_reg == $past(s.memory_address_reg) + AW'(1))
        else $error("byte step not one");

    a_pack_step: assert property (
        s.st == ST_DEND && !s.rd_phase && s.pack &&
            s.mstep == STEP_DOWN |=> s.memory_address_reg == $past(s.memory_address_reg) - AW'(2))
        else $error("packed step not two");

    a_cfg_refused: assert property (
        start_wr && cfg_bad |=> s.cfg_err && !s.act ##1 s.st == ST_IDLE)
        else $error("bad setup started the channel");
endmodule

// file: hdl/dcts_pkg.sv
// constants shared by the dma channel transfer sequencer
// assumes an apb master with 8-bit byte addresses and 32-bit data
package dcts_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_DCR = 8'h00;
    localparam logic [7:0] OFF_OCR = 8'h04;
    localparam logic [7:0] OFF_SCR = 8'h08;
    localparam logic [7:0] OFF_MAR = 8'h0C;
    localparam logic [7:0] OFF_DAR = 8'h10;
    localparam logic [7:0] OFF_MTC = 8'h14;
    localparam logic [7:0] OFF_CTL = 8'h18;
    localparam logic [7:0] OFF_STAT = 8'h1C;
    // field positions
    localparam int DCR_TYPE_LSB = 0;
    localparam int DCR_PORT_BIT = 2;
    localparam int OCR_SIZE_LSB = 0;
    localparam int OCR_REQUEST_GEN_SEL_LSB = 2;
    localparam int SCR_MAC_LSB = 0;
    localparam int SCR_DAC_LSB = 2;
    localparam int CTL_START_BIT = 0;
    localparam int CTL_DIR_BIT = 1;
    localparam int STAT_ACT_BIT = 0;
    localparam int STAT_CFG_BIT = 1;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_PCL_BIT = 3;
    // operand size codes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;
    localparam logic [1:0] SIZE_RSVD = 2'h3;
    // device type codes
    localparam logic [1:0] TYPE_ACK = 2'h2;
    localparam logic [1:0] TYPE_ACK_RDY = 2'h3;
    // address count codes
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_UP = 2'h1;
    localparam logic [1:0] STEP_DOWN = 2'h2;
    localparam logic [1:0] STEP_RSVD = 2'h3;
    // request generation codes
    localparam logic [1:0] REQUEST_GEN_SEL_MIX = 2'h3;
    // port width codes
    localparam logic PORT_8 = 1'h0;
    localparam logic PORT_16 = 1'h1;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ARB, ST_SACK, ST_SDTC, ST_SEND, ST_DCYC, ST_DEND
    } dcts_st_t;
endpackage

// file: bench/dcts_periph.sv
// peripheral on the request, acknowledge and ready lines
// assumes the channel clock and level signalling on every line
`timescale 1ns/1ps
module dcts_periph (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] lat,
    input wire logic to_mem,
    input wire logic ack_n,
    output logic req_n,
    output logic ready_n,
    output logic [15:0] dev_data,
    output logic dev_oe
);
    logic [1:0] wait_q;
    // one request per operand; ready only once data is out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_n <= 1'b1;
            ready_n <= 1'b1;
            dev_data <= 16'h5a3c;
            dev_oe <= 1'b0;
            wait_q <= 2'h0;
        end else if (ack_n) begin
            req_n <= 1'b0;
            ready_n <= 1'b1;
            dev_oe <= 1'b0;
            // released data lines wander so stale data never matches
            dev_data <= {dev_data[14:0], dev_data[15] ^ dev_data[10]};
            wait_q <= 2'h0;
        end else begin
            req_n <= 1'b1;
            dev_oe <= to_mem;
            // ready answers every acknowledged cycle
            if (dev_oe == to_mem && wait_q == lat) begin
                ready_n <= 1'b0;
            end else if (wait_q != lat) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

// file: bench/dcts_top_tb.sv
// self-checking bench for the dma channel transfer sequencer
// assumes dcts_periph on the handshake; memory is modelled here
`timescale 1ns/1ps
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("BAD %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module dcts_top_tb;
    import dcts_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, rerr, bus_request, ack_n, ready_n, dtc_n;
    logic bus_grant = 1'b0;
    logic mack_n = 1'b1;
    logic lds_n, uds_n, as_n, mem_read, data_oe, dev_oe, req_n;
    logic to_mem = 1'b0;
    logic chk_on = 1'b0;
    logic is_byte = 1'b0;
    logic [1:0] lat = 2'h0;
    logic [1:0] mlat = 2'h0;
    logic [1:0] mwait = 2'h0;
    logic [23:0] mem_addr, exp_a;
    logic [1:0] exp_l;
    logic [15:0] data_out, dev_data, bus, msk;
    logic [15:0] mem [256];
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int step;
    // bad configurations: type, port, size, request code
    localparam logic [6:0] BAD [6] = '{{TYPE_ACK_RDY, PORT_8, SIZE_RSVD,
        2'h0}, {TYPE_ACK_RDY, PORT_16, SIZE_BYTE, 2'h0}, {TYPE_ACK_RDY,
        PORT_8, SIZE_WORD, 2'h0}, {2'h0, PORT_16, SIZE_BYTE, 2'h2},
        {2'h0, PORT_16, SIZE_BYTE, 2'h3}, {TYPE_ACK, PORT_8, SIZE_BYTE,
        2'h0}};

    initial begin
        forever #25 pclk = ~pclk;
    end

    // shared data bus: whoever drives wins, else it wanders
    assign msk = ~{{8{uds_n}}, {8{lds_n}}};
    assign bus = data_oe ? data_out : dev_oe ? dev_data :
        (mem_read && !as_n) ? mem[mem_addr[8:1]] : ~cyc[15:0];

    dcts_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_request(bus_request),
        .bus_grant(bus_grant), .req_n(req_n), .ack_n(ack_n),
        .peripheral_control_line_n(ready_n),
        .transfer_complete_strobe_n(dtc_n),
        .lower_byte_strobe_n(lds_n), .upper_byte_strobe_n(uds_n),
        .addr_strobe_n(as_n), .mem_read(mem_read), .mem_addr(mem_addr),
        .memory_cycle_ack_n(mack_n), .data_in(bus), .data_out(data_out),
        .data_oe(data_oe)
    );
    dcts_periph i_dev (
        .pclk(pclk), .presetn(presetn), .lat(lat), .to_mem(to_mem),
        .ack_n(ack_n), .req_n(req_n), .ready_n(ready_n),
        .dev_data(dev_data), .dev_oe(dev_oe)
    );

    // memory answers after mlat cycles; operand checks at each strobe
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        bus_grant <= bus_request;
        if (as_n) begin
            mack_n <= 1'b1;
            mwait <= 2'h0;
        end else if (mwait == mlat) begin
            mack_n <= 1'b0;
        end else begin
            mwait <= mwait + 2'h1;
        end
        if (!as_n && !mack_n && !mem_read) begin
            mem[mem_addr[8:1]] <= (mem[mem_addr[8:1]] & ~msk) | (bus & msk);
        end
        if (!dtc_n && chk_on) begin
            `CHK(mem_addr, exp_a)
            exp_l = is_byte ? {exp_a[0], ~exp_a[0]} : 2'b00;
            `CHK({uds_n, lds_n}, exp_l)
            `CHK({ack_n, ready_n, mack_n, mem_read}, {3'h0, ~to_mem})
            if (to_mem) `CHK(mem[mem_addr[8:1]] & msk, dev_data & msk)
            exp_a = exp_a + 24'(step);
        end
        // cut a hang short well past the expected run length
        if (cyc > 50000) begin
            fails++;
            report_and_stop();
        end
    end

    function automatic int sgn(input logic [1:0] m);
        return m == STEP_UP ? 1 : m == STEP_DOWN ? -1 : 0;
    endfunction

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no answer time assumed; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask

    task automatic setup(input logic [1:0] ty, input logic pw,
            input logic [1:0] sz, rq, mc, dc, input logic [23:0] ma, da,
            input logic [15:0] n);
        apb(1'b1, OFF_DCR, {29'h0, pw, ty});
        apb(1'b1, OFF_OCR, {28'h0, rq, sz});
        apb(1'b1, OFF_SCR, {28'h0, dc, mc});
        apb(1'b1, OFF_MAR, {8'h0, ma});
        apb(1'b1, OFF_DAR, {8'h0, da});
        apb(1'b1, OFF_MTC, {16'h0, n});
    endtask

    // start, poll until done, then clear the sticky flags
    task automatic go(input logic dir);
        apb(1'b1, OFF_CTL, {30'h0, dir, 1'b1});
        do begin
            apb(1'b0, OFF_STAT, 32'h0);
        end while (rdat[STAT_DONE_BIT] !== 1'b1);
        `CHK(rdat[STAT_ACT_BIT], 1'b0)
        apb(1'b1, OFF_STAT, 32'h0000_0006);
    endtask

    task automatic report_and_stop();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        logic [1:0] sz, mc, dc;
        logic [23:0] ma;
        logic [15:0] n;
        logic dir, pw;
        int ms, ds;
        void'($urandom(13764));
        foreach (mem[i]) mem[i] = 16'($urandom);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_DCR, 32'h0);
        rd(OFF_STAT, 32'h0000_0008);
        apb(1'b0, 8'h20, 32'h0);
        `CHK(rerr, 1'b1)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            setup(BAD[i][6:5], BAD[i][4], BAD[i][3:2], BAD[i][1:0],
                STEP_UP, STEP_UP, 24'h40, 24'h100, 16'h2);
            apb(1'b1, OFF_CTL, 32'h0000_0003);
            rd(OFF_STAT, 32'h0000_000a);
            `CHK(bus_request, 1'b0)
            apb(1'b1, OFF_STAT, 32'h0000_0006);
        end
        $display("test config errors done");
        // single mode: both sizes, all count modes, both directions
        for (int c = 0; c < 12; c++) begin
            pw = c[0];
            dir = c >= 6;
            mc = 2'((c / 2) % 3);
            n = 16'(1 + $urandom % 4);
            ma = 24'h80 + (pw ? 24'h0 : 24'($urandom % 2));
            step = sgn(mc) * (pw ? 2 : 1);
            lat <= 2'($urandom);
            mlat <= 2'($urandom);
            to_mem <= ~dir;
            is_byte = ~pw;
            exp_a = ma;
            chk_on = 1'b1;
            setup(TYPE_ACK_RDY, pw, pw ? SIZE_WORD : SIZE_BYTE,
                2'($urandom), mc, STEP_UP, ma, 24'h0, n);
            rd(OFF_DCR, {29'h0, pw, TYPE_ACK_RDY});
            go(dir);
            `CHK(exp_a, ma + 24'(step * n))
            rd(OFF_MAR, {8'h0, ma + 24'(step * n)});
            rd(OFF_MTC, 32'h0);
        end
        chk_on = 1'b0;
        $display("test single mode done");
        // dual mode: every port and size, packing for 16-bit bytes
        for (int c = 0; c < 6; c++) begin
            pw = c >= 3;
            sz = 2'(c % 3);
            mc = 2'($urandom % 3);
            dc = 2'($urandom % 3);
            n = 16'(1 + $urandom % 3);
            ma = 24'h40 + ((sz == SIZE_BYTE) ? 24'($urandom % 2) : 24'h0);
            ms = 1 << sz;
            ds = pw ? ms : 2 * ms;
            dir = 1'($urandom);
            // corners: packed bytes counting down with an odd count,
            // and a word copy whose destination is checked afterwards
            if (c == 3) begin
                mc = STEP_DOWN;
                dc = STEP_UP;
                ma = 24'h40;
                n = 16'h3;
            end else if (c == 4) begin
                mc = STEP_UP;
                dc = STEP_UP;
                ma = 24'h40;
                dir = 1'b1;
            end
            setup(2'($urandom % 2), pw, sz, 2'h0, mc, dc, ma, 24'h100, n);
            go(dir);
            exp_a = ma + 24'(sgn(mc) * ms * n);
            rd(OFF_MAR, {8'h0, exp_a});
            exp_a = 24'h100 + 24'(sgn(dc) * ds * n);
            rd(OFF_DAR, {8'h0, exp_a});
            rd(OFF_MTC, 32'h0);
            // device words must now hold the memory words in order
            for (int k = 0; k < int'(n) && c == 4; k++) begin
                `CHK(mem[8'h80 + 8'(k)], mem[8'h20 + 8'(k)])
            end
        end
        $display("test dual mode done");
        report_and_stop();
    end
endmodule
